// File: src/acm_pkg.sv
// Purpose: shared constants and carriers for the audio clock monitor register bank
// Assumes: byte-wide control port behind the serial control engine, two pages
// Notes: reserved bits are kept as plain read/write storage, except pin level bits 2-0, which read 0
package acm_pkg;

    // page select register, present on every page
    localparam logic [7:0] ACM_PAGE_SEL_OFS = 8'h00;

    // page 0 status registers
    localparam logic [7:0] ACM_RATE_RATIO_OFS = 8'h5B;
    localparam logic [7:0] ACM_BCLK_UPPER_OFS = 8'h5C;
    localparam logic [7:0] ACM_BCLK_LOWER_OFS = 8'h5D;
    localparam logic [7:0] ACM_CLK_DET_OFS = 8'h5E;
    localparam logic [7:0] ACM_CLK_ERR_OFS = 8'h5F;
    localparam logic [7:0] ACM_AMUTE_MON_OFS = 8'h6C;
    localparam logic [7:0] ACM_PIN_LEVEL_OFS = 8'h77;
    localparam logic [7:0] ACM_AUTO_MUTE_OFS = 8'h78;

    // page 1 analog configuration registers
    localparam logic [7:0] ACM_AMP_TYPE_OFS = 8'h01;
    localparam logic [7:0] ACM_GAIN_OFS = 8'h02;
    localparam logic [7:0] ACM_UVP_OFS = 8'h05;
    localparam logic [7:0] ACM_MUTE_FOLLOW_OFS = 8'h06;
    localparam logic [7:0] ACM_BOOST_OFS = 8'h07;
    localparam logic [7:0] ACM_RAMP_OFS = 8'h08;
    localparam logic [7:0] ACM_DEEMPH_VREF_OFS = 8'h09;

    // writable (storage) bits of the page 0 registers; others are live status, except pin level bits 2-0, which read 0
    localparam logic [7:0] ACM_RATE_RATIO_RW = 8'h80;
    localparam logic [7:0] ACM_BCLK_UPPER_RW = 8'hFE;
    localparam logic [7:0] ACM_BCLK_LOWER_RW = 8'h7F;
    localparam logic [7:0] ACM_CLK_DET_RW = 8'h80;
    localparam logic [7:0] ACM_CLK_ERR_RW = 8'hE8;
    localparam logic [7:0] ACM_AMUTE_MON_RW = 8'hFC;
    localparam logic [7:0] ACM_PIN_LEVEL_RW = 8'hC0;
    localparam logic [7:0] ACM_AUTO_MUTE_RW = 8'hEE;

    // reset values
    localparam logic [7:0] ACM_PAGE0_RST = 8'h00;
    localparam logic [7:0] ACM_AMP_TYPE_RST = 8'h00;
    localparam logic [7:0] ACM_GAIN_RST = 8'h00;
    localparam logic [7:0] ACM_UVP_RST = 8'h00;
    localparam logic [7:0] ACM_MUTE_FOLLOW_RST = 8'h01;
    localparam logic [7:0] ACM_BOOST_RST = 8'h01;
    localparam logic [7:0] ACM_RAMP_RST = 8'h01;
    localparam logic [7:0] ACM_DEEMPH_VREF_RST = 8'h01;

    // field positions
    localparam int ACM_RATE_LSB = 4;
    localparam int ACM_LEFT_BIT = 4;
    localparam int ACM_RIGHT_BIT = 0;
    localparam int ACM_HALT_LATCH_BIT = 4;
    localparam int ACM_CLK_MISS_BIT = 2;
    localparam int ACM_RESYNC_BIT = 1;
    localparam int ACM_CLK_FAULT_BIT = 0;
    localparam int ACM_GENERAL_PIN2_LEVEL_BIT = 5;
    localparam int ACM_MUTE_PIN_BIT = 4;
    localparam int ACM_GENERAL_PIN0_LEVEL_BIT = 3;
    localparam int ACM_EXT_UVP_BIT = 1;
    localparam int ACM_INT_UVP_BIT = 0;
    localparam int ACM_DEEMPH_BIT = 1;
    localparam int ACM_VREF_PD_BIT = 0;

    // detector codes and bit clock ratio limits
    localparam logic [2:0] ACM_RATE_ERROR = 3'h0;
    localparam logic [3:0] ACM_RATIO_ERROR = 4'h0;
    localparam logic [8:0] ACM_BCLK_MIN = 9'h020;
    localparam logic [8:0] ACM_BCLK_MAX = 9'h100;

    localparam logic [7:0] ACM_UNMAPPED_DATA = 8'h00;

    // observations from the clock detector and analog front end
    typedef struct packed {
        logic [2:0] detected_sample_rate;
        logic [3:0] detected_master_clock_ratio;
        logic [8:0] detected_bit_clock_ratio;
        logic bit_ratio_stable;
        logic mclk_halted;
        logic pll_enabled;
        logic pll_locked;
        logic frame_clk_missing;
        logic bit_clk_missing;
        logic auto_config_bad;
        logic frame_low_short;
        logic error_ignore;
        logic resync_busy;
        logic clock_error_event;
    } acm_det_s;

    typedef struct packed {
        logic left_analog_muted;
        logic right_analog_muted;
        logic left_auto_muted;
        logic right_auto_muted;
        logic general_pin2;
        logic mute_pin;
        logic general_pin0;
        logic digital_mute;
    } acm_ana_s;

    // configuration driven into the analog section
    typedef struct packed {
        logic output_amplitude_select;
        logic left_analog_attenuation;
        logic right_analog_attenuation;
        logic left_amplitude_boost;
        logic right_amplitude_boost;
        logic external_supply_drop_enable;
        logic internal_supply_drop_enable;
        logic deemphasis_pin_enable;
        logic common_ref_power_down;
        logic left_analog_mute;
        logic right_analog_mute;
    } acm_cfg_s;

endpackage

// File: src/acm_status_regs.sv
// Purpose: host-visible clock monitor status and analog configuration registers
// Assumes: byte accesses arrive as one-cycle strobes from the control port engine
// Notes: read data is registered; read-to-clear flags clear on the read strobe
//
// Summary of operation
// - detected sample rate code reads in bits 6-4 of the rate register.
// - detected master clock ratio code reads in bits 3-0, 0000 disallowed.
// - clock error may flag with valid ratio; master clock stays below 50 MHz.
// - bit clock ratio split: upper bit 0 of one register, lower bit 7 next.
// - detector bit 6 reads 1 while master clock is halted.
// - detector bit 5 reads 1 when pll unlocked or disabled.
// - detector bit 4 is 1 only when frame and bit clocks both missing; mirrored.
// - detector bit 3 reads 1 when auto clock configuration impossible.
// - detector bit 2 reads 1 for undetectable ratio or short frame low period.
// - detector bit 1 reads 0 only for stable bit clock ratio within 32-256.
// - detector bit 0 flags undetectable rate, suppressed while errors ignored.
// - halt latch bit 4 sets on master clock halt, cleared by reading.
// - resync bit 1 reads high while resynchronisation is in progress.
// - clock fault bit 0 sets on clock error, cleared by reading.
// - analog mute monitors read 0 when muted, 1 when unmuted.
// - pin level register shows general pin 2, mute pin, general pin 0.
// - auto mute flags read 1 per auto muted channel.
// - per channel attenuation 0/-6 dB and +10% boost, boost resets left off.
// - writing 1 disables the external or internal supply drop detector.
// - analog mute follows digital mute while follow bit is 1, reset 1.
// - de-emphasis pin use bit 1; common reference power down bit 0, reset 1.
`timescale 1ns/1ps

module acm_status_regs
    import acm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire acm_det_s det,
    input wire acm_ana_s ana,
    output acm_cfg_s cfg
);

    // page select and storage
    logic [7:0] page;
    logic [7:0] rate_ratio_st;
    logic [7:0] bclk_upper_st;
    logic [7:0] bclk_lower_st;
    logic [7:0] clk_det_st;
    logic [7:0] clk_err_st;
    logic [7:0] amute_mon_st;
    logic [7:0] pin_level_st;
    logic [7:0] auto_mute_st;
    logic [7:0] amp_type;
    logic [7:0] gain;
    logic [7:0] uvp;
    logic [7:0] mute_follow;
    logic [7:0] boost;
    logic [7:0] ramp;
    logic [7:0] deemph_vref;

    // live status snapshot and latched flags
    logic [7:0] clk_det_live;
    logic halt_latch;
    logic fault_latch;
    logic halted_d;
    logic [7:0] next_rdata;

    logic on_page0;
    logic on_page1;
    logic wr0;
    logic wr1;
    logic err_read;
    logic halt_rise;
    logic bclk_ok;

    assign on_page0 = (page == ACM_PAGE0_RST);
    assign on_page1 = (page == 8'h01);
    assign wr0 = reg_wr && on_page0;
    assign wr1 = reg_wr && on_page1;
    assign err_read = reg_rd && on_page0 && (reg_addr == ACM_CLK_ERR_OFS);
    assign halt_rise = det.mclk_halted && !halted_d;
    assign bclk_ok = det.bit_ratio_stable
        && (det.detected_bit_clock_ratio >= ACM_BCLK_MIN)
        && (det.detected_bit_clock_ratio <= ACM_BCLK_MAX);

    // page select reachable from every page
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            page <= ACM_PAGE0_RST;
        end else if (reg_wr && reg_addr == ACM_PAGE_SEL_OFS) begin
            page <= reg_wdata;
        end
    end

    // page 0 reserved storage; status bits masked out so writes cannot land
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rate_ratio_st <= ACM_PAGE0_RST;
            bclk_upper_st <= ACM_PAGE0_RST;
            bclk_lower_st <= ACM_PAGE0_RST;
            clk_det_st <= ACM_PAGE0_RST;
            clk_err_st <= ACM_PAGE0_RST;
            amute_mon_st <= ACM_PAGE0_RST;
            pin_level_st <= ACM_PAGE0_RST;
            auto_mute_st <= ACM_PAGE0_RST;
        end else if (wr0) begin
            unique case (reg_addr)
                ACM_RATE_RATIO_OFS: rate_ratio_st <= reg_wdata & ACM_RATE_RATIO_RW;
                ACM_BCLK_UPPER_OFS: bclk_upper_st <= reg_wdata & ACM_BCLK_UPPER_RW;
                ACM_BCLK_LOWER_OFS: bclk_lower_st <= reg_wdata & ACM_BCLK_LOWER_RW;
                ACM_CLK_DET_OFS: clk_det_st <= reg_wdata & ACM_CLK_DET_RW;
                ACM_CLK_ERR_OFS: clk_err_st <= reg_wdata & ACM_CLK_ERR_RW;
                ACM_AMUTE_MON_OFS: amute_mon_st <= reg_wdata & ACM_AMUTE_MON_RW;
                ACM_PIN_LEVEL_OFS: pin_level_st <= reg_wdata & ACM_PIN_LEVEL_RW;
                ACM_AUTO_MUTE_OFS: auto_mute_st <= reg_wdata & ACM_AUTO_MUTE_RW;
                default: begin
                end
            endcase
        end
    end

    // page 1 configuration, full bytes kept so reserved bits read back
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            amp_type <= ACM_AMP_TYPE_RST;
            gain <= ACM_GAIN_RST;
            uvp <= ACM_UVP_RST;
            mute_follow <= ACM_MUTE_FOLLOW_RST;
            boost <= ACM_BOOST_RST;
            ramp <= ACM_RAMP_RST;
            deemph_vref <= ACM_DEEMPH_VREF_RST;
        end else if (wr1) begin
            unique case (reg_addr)
                ACM_AMP_TYPE_OFS: amp_type <= reg_wdata;
                ACM_GAIN_OFS: gain <= reg_wdata;
                ACM_UVP_OFS: uvp <= reg_wdata;
                ACM_MUTE_FOLLOW_OFS: mute_follow <= reg_wdata;
                ACM_BOOST_OFS: boost <= reg_wdata;
                ACM_RAMP_OFS: ramp <= reg_wdata;
                ACM_DEEMPH_VREF_OFS: deemph_vref <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // clock detector status snapshot; one flop of delay keeps reads glitch free
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_det_live <= 8'h00;
        end else begin
            clk_det_live[7] <= 1'b0;
            clk_det_live[6] <= det.mclk_halted;
            clk_det_live[5] <= !(det.pll_enabled && det.pll_locked);
            clk_det_live[4] <= det.frame_clk_missing && det.bit_clk_missing;
            clk_det_live[3] <= det.auto_config_bad;
            clk_det_live[2] <= (det.detected_master_clock_ratio == ACM_RATIO_ERROR)
                || det.frame_low_short;
            clk_det_live[1] <= !bclk_ok;
            // error-ignore lets the converter run again, so the flag drops
            clk_det_live[0] <= (det.detected_sample_rate == ACM_RATE_ERROR)
                && !det.error_ignore;
        end
    end

    // halt edge detector
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            halted_d <= 1'b0;
        end else begin
            halted_d <= det.mclk_halted;
        end
    end

    // read-to-clear latches; a new event in the read cycle survives the clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            halt_latch <= 1'b0;
            fault_latch <= 1'b0;
        end else begin
            if (halt_rise) begin
                halt_latch <= 1'b1;
            end else if (err_read) begin
                halt_latch <= 1'b0;
            end
            // pll-off ratio shortfalls arrive here as ordinary error events
            if (det.clock_error_event) begin
                fault_latch <= 1'b1;
            end else if (err_read) begin
                fault_latch <= 1'b0;
            end
        end
    end

    // read multiplexer: storage bits merged with live status bits
    always_comb begin
        next_rdata = ACM_UNMAPPED_DATA;
        if (reg_addr == ACM_PAGE_SEL_OFS) begin
            next_rdata = page;
        end else if (on_page0) begin
            unique case (reg_addr)
                ACM_RATE_RATIO_OFS: begin
                    next_rdata = rate_ratio_st;
                    next_rdata[6:ACM_RATE_LSB] = det.detected_sample_rate;
                    next_rdata[3:0] = det.detected_master_clock_ratio;
                end
                ACM_BCLK_UPPER_OFS: begin
                    next_rdata = bclk_upper_st;
                    next_rdata[0] = det.detected_bit_clock_ratio[8];
                end
                ACM_BCLK_LOWER_OFS: begin
                    // only the lowest ratio bit fits; value is meaningless at ratio one
                    next_rdata = bclk_lower_st;
                    next_rdata[7] = det.detected_bit_clock_ratio[0];
                end
                ACM_CLK_DET_OFS: begin
                    next_rdata = clk_det_st | clk_det_live;
                end
                ACM_CLK_ERR_OFS: begin
                    next_rdata = clk_err_st;
                    next_rdata[ACM_HALT_LATCH_BIT] = halt_latch;
                    next_rdata[ACM_CLK_MISS_BIT] = clk_det_live[4];
                    next_rdata[ACM_RESYNC_BIT] = det.resync_busy;
                    next_rdata[ACM_CLK_FAULT_BIT] = fault_latch;
                end
                ACM_AMUTE_MON_OFS: begin
                    next_rdata = amute_mon_st;
                    next_rdata[1] = !ana.left_analog_muted;
                    next_rdata[0] = !ana.right_analog_muted;
                end
                ACM_PIN_LEVEL_OFS: begin
                    next_rdata = pin_level_st;
                    next_rdata[ACM_GENERAL_PIN2_LEVEL_BIT] = ana.general_pin2;
                    next_rdata[ACM_MUTE_PIN_BIT] = ana.mute_pin;
                    next_rdata[ACM_GENERAL_PIN0_LEVEL_BIT] = ana.general_pin0;
                end
                ACM_AUTO_MUTE_OFS: begin
                    next_rdata = auto_mute_st;
                    next_rdata[ACM_LEFT_BIT] = ana.left_auto_muted;
                    next_rdata[ACM_RIGHT_BIT] = ana.right_auto_muted;
                end
                default: begin
                    next_rdata = ACM_UNMAPPED_DATA;
                end
            endcase
        end else if (on_page1) begin
            unique case (reg_addr)
                ACM_AMP_TYPE_OFS: next_rdata = amp_type;
                ACM_GAIN_OFS: next_rdata = gain;
                ACM_UVP_OFS: next_rdata = uvp;
                ACM_MUTE_FOLLOW_OFS: next_rdata = mute_follow;
                ACM_BOOST_OFS: next_rdata = boost;
                ACM_RAMP_OFS: next_rdata = ramp;
                ACM_DEEMPH_VREF_OFS: next_rdata = deemph_vref;
                default: next_rdata = ACM_UNMAPPED_DATA;
            endcase
        end
    end

    // read data held until the next read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // configuration outputs, registered so the analog side sees clean levels
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg <= '0;
        end else begin
            cfg.output_amplitude_select <= amp_type[0];
            cfg.left_analog_attenuation <= gain[ACM_LEFT_BIT];
            cfg.right_analog_attenuation <= gain[ACM_RIGHT_BIT];
            cfg.left_amplitude_boost <= boost[ACM_LEFT_BIT];
            cfg.right_amplitude_boost <= boost[ACM_RIGHT_BIT];
            cfg.external_supply_drop_enable <= !uvp[ACM_EXT_UVP_BIT];
            cfg.internal_supply_drop_enable <= !uvp[ACM_INT_UVP_BIT];
            cfg.deemphasis_pin_enable <= deemph_vref[ACM_DEEMPH_BIT];
            cfg.common_ref_power_down <= deemph_vref[ACM_VREF_PD_BIT];
            cfg.left_analog_mute <= mute_follow[0] && ana.digital_mute;
            cfg.right_analog_mute <= mute_follow[0] && ana.digital_mute;
        end
    end

endmodule

// File: verification/acm_status_regs_monitor.sv
// Purpose: port-level checks on the clock monitor register bank
// Assumes: one read or write strobe a cycle, page select at offset 0x00
// Notes: page is mirrored here from the write strobes; reads see the old page
`timescale 1ns/1ps
module acm_status_regs_monitor
    import acm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire acm_det_s det,
    input wire acm_ana_s ana,
    input wire acm_cfg_s cfg
);
    logic [7:0] pg;
    logic [2:0] st_q;
    logic rd0;

    // page mirror, so page 0 offsets are only checked on page 0
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pg <= 8'h00;
        end else if (reg_wr && reg_addr == ACM_PAGE_SEL_OFS) begin
            pg <= reg_wdata;
        end
    end

    // detector levels one cycle late, as the status register samples them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= 3'h0;
        end else begin
            st_q <= {det.mclk_halted, !(det.pll_enabled && det.pll_locked),
                det.frame_clk_missing && det.bit_clk_missing};
        end
    end

    assign rd0 = reg_rd && pg == 8'h00;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    property p_rvalid;
        reg_rvalid == $past(reg_rd);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after strobe");
    property p_rate;
        rd0 && reg_addr == ACM_RATE_RATIO_OFS |=>
            reg_rdata[6:0] == $past({det.detected_sample_rate, det.detected_master_clock_ratio});
    endproperty
    a_rate: assert property (p_rate) else $error("rate or ratio field wrong");
    property p_bclk;
        rd0 && reg_addr == ACM_BCLK_UPPER_OFS |=>
            reg_rdata[0] == $past(det.detected_bit_clock_ratio[8]);
    endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock ratio upper bit wrong");
    property p_st;
        rd0 && reg_addr == ACM_CLK_DET_OFS |=> reg_rdata[6:4] == $past(st_q);
    endproperty
    a_st: assert property (p_st) else $error("clock detector status bits 6-4 wrong");
    property p_resync;
        rd0 && reg_addr == ACM_CLK_ERR_OFS |=> reg_rdata[2:1] == $past({st_q[0], det.resync_busy});
    endproperty
    a_resync: assert property (p_resync) else $error("resync or missing flag wrong");
    property p_amute;
        rd0 && reg_addr == ACM_AMUTE_MON_OFS |=>
            reg_rdata[1:0] == ~$past({ana.left_analog_muted, ana.right_analog_muted});
    endproperty
    a_amute: assert property (p_amute) else $error("analog mute monitor wrong");
    property p_automute;
        rd0 && reg_addr == ACM_AUTO_MUTE_OFS |=>
            {reg_rdata[4], reg_rdata[0]} == $past({ana.left_auto_muted, ana.right_auto_muted});
    endproperty
    a_automute: assert property (p_automute) else $error("auto mute flags wrong");
    property p_follow;
        !ana.digital_mute |=> !cfg.left_analog_mute && !cfg.right_analog_mute;
    endproperty
    a_follow: assert property (p_follow) else $error("analog mute without digital mute");
    property p_unmapped;
        reg_rd && pg > 8'h01 && reg_addr != ACM_PAGE_SEL_OFS |=> reg_rdata == ACM_UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped page read not zero");
endmodule

// File: verification/acm_host_model.sv
// Purpose: host side of the control port, issuing byte reads and writes
// Assumes: one access at a time, strobes launched just after a clock edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module acm_host_model (
    input wire logic sys_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // write strobe stands for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // address held until the valid pulse; bounded so a dead port cannot hang
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        ok = 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge sys_clk);
            ok = (reg_rvalid === 1'b1);
        end
        d = reg_rdata;
        reg_addr <= ~a;
    endtask
endmodule

// File: verification/acm_status_regs_tb_top.sv
// Purpose: self-checking bench for the clock monitor register bank
// Assumes: detector and analog levels driven here, host model drives strobes
// Notes: random levels from a fixed seed plus directed latch and page cases
`timescale 1ns/1ps
module acm_status_regs_tb_top
    import acm_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    acm_det_s det = '0;
    acm_ana_s ana = '0;
    acm_cfg_s cfg;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 3;
    logic [7:0] pg = 8'h00;
    logic [7:0] sh [256];
    logic [7:0] p1 [16];
    logic [7:0] pa [7] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
    logic [7:0] pz [8] = '{8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h6C, 8'h77, 8'h78, 8'h10};
    logic [8:0] cr [4] = '{9'h01F, 9'h020, 9'h100, 9'h101};

    always #10 sys_clk = ~sys_clk;

    acm_status_regs u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .det(det), .ana(ana), .cfg(cfg));
    acm_host_model u_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %0h expected %0h", $time, got, exp);
        end
    endtask

    // a lost valid pulse ends the run rather than waiting on
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            fail_count++;
            stop_test();
        end else begin
            chk({8'h00, d}, {8'h00, e});
        end
    endtask

    // storage bits of page 0; status positions never take a write
    function automatic logic [7:0] rwm(input logic [7:0] a);
        case (a)
            8'h5B: return 8'h80;
            8'h5C: return 8'hFE;
            8'h5D: return 8'h7F;
            8'h5E: return 8'h80;
            8'h5F: return 8'hE8;
            8'h6C: return 8'hFC;
            8'h77: return 8'hC0;
            8'h78: return 8'hEE;
            default: return 8'h00;
        endcase
    endfunction

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        u_host.wr(a, d);
        if (a == 8'h00) pg = d;
        else if (pg == 8'h00) sh[a] = d & rwm(a);
        else if (pg == 8'h01) p1[a[3:0]] = d;
    endtask

    function automatic logic [7:0] live(input logic [7:0] a);
        logic bb;
        bb = !(det.bit_ratio_stable && det.detected_bit_clock_ratio >= 9'h020
            && det.detected_bit_clock_ratio <= 9'h100);
        case (a)
            8'h5B: return {1'b0, det.detected_sample_rate, det.detected_master_clock_ratio};
            8'h5C: return {7'h00, det.detected_bit_clock_ratio[8]};
            8'h5D: return {det.detected_bit_clock_ratio[0], 7'h00};
            8'h5E: return {1'b0, det.mclk_halted, !(det.pll_enabled && det.pll_locked),
                det.frame_clk_missing && det.bit_clk_missing, det.auto_config_bad,
                det.detected_master_clock_ratio == 4'h0 || det.frame_low_short, bb,
                det.detected_sample_rate == 3'h0 && !det.error_ignore};
            8'h6C: return {6'h00, !ana.left_analog_muted, !ana.right_analog_muted};
            8'h77: return {2'h0, ana.general_pin2, ana.mute_pin, ana.general_pin0, 3'h0};
            8'h78: return {3'h0, ana.left_auto_muted, 3'h0, ana.right_auto_muted};
            default: return 8'h00;
        endcase
    endfunction

    function automatic acm_cfg_s ecfg();
        logic m;
        m = p1[6][0] && ana.digital_mute;
        return {p1[1][0], p1[2][4], p1[2][0], p1[7][4], p1[7][0], !p1[5][1], !p1[5][0],
            p1[9][1], p1[9][0], m, m};
    endfunction

    initial begin
        logic [7:0] a;
        logic [7:0] d;
        acm_det_s nd;
        bit ok;
        for (int i = 0; i < 256; i++) sh[i] = 8'h00;
        for (int i = 0; i < 16; i++) p1[i] = (i >= 6 && i <= 9) ? 8'h01 : 8'h00;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        // page 1 reset values, then random writes with digital mute toggling
        put(8'h00, 8'h01);
        chk({5'h00, cfg}, {5'h00, ecfg()});
        for (int i = 0; i < 7; i++) rdchk(pa[i], p1[pa[i][3:0]]);
        for (int i = 0; i < 21; i++) begin
            a = pa[i % 7];
            d = 8'($random(seed));
            ana.digital_mute <= d[7];
            put(a, 8'($random(seed)));
            rdchk(a, p1[a[3:0]]);
            chk({5'h00, cfg}, {5'h00, ecfg()});
        end
        // unmapped page reads zero and drops writes
        put(8'h00, 8'h02);
        rdchk(8'h06, 8'h00);
        put(8'h06, 8'hFE);
        put(8'h00, 8'h01);
        rdchk(8'h06, p1[6]);
        // page 0 with random detector levels and corner bit clock ratios
        put(8'h00, 8'h00);
        for (int i = 0; i < 96; i++) begin
            nd = acm_det_s'(27'($random(seed)));
            nd.clock_error_event = 1'b0;
            if (i < 32) begin
                nd.detected_bit_clock_ratio = cr[i / 8];
                nd.bit_ratio_stable = 1'b1;
            end
            det <= nd;
            ana <= acm_ana_s'(8'($random(seed)));
            a = pz[i % 8];
            put(a, 8'($random(seed)));
            rdchk(a, sh[a] | live(a));
        end
        // latched halt and fault flags clear on read
        nd = '0;
        det <= nd;
        put(8'h5F, 8'hFF);
        u_host.rd(8'h5F, d, ok);
        rdchk(8'h5F, sh[8'h5F]);
        nd.mclk_halted = 1'b1;
        nd.resync_busy = 1'b1;
        nd.frame_clk_missing = 1'b1;
        nd.bit_clk_missing = 1'b1;
        det <= nd;
        rdchk(8'h5F, sh[8'h5F] | 8'h16);
        rdchk(8'h5F, sh[8'h5F] | 8'h06);
        nd.clock_error_event = 1'b1;
        det <= nd;
        @(posedge sys_clk);
        nd.clock_error_event = 1'b0;
        det <= nd;
        rdchk(8'h5F, sh[8'h5F] | 8'h07);
        rdchk(8'h5F, sh[8'h5F] | 8'h06);
        stop_test();
    end
endmodule

bind acm_status_regs acm_status_regs_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .det(det), .ana(ana), .cfg(cfg));
